// >>> src/arc_config_bank.sv
// page 1 register bank for serial port roles, channel limit and rate converter control
`default_nettype none
module arc_config_bank (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic primary_role_select,
  input wire logic secondary_role_select,
  input wire logic [3:0] standard_channel_limit_select,
  input wire logic main_rate_auto_primary,
  output logic [7:0] active_page,
  output logic primary_bclk_out_en,
  output logic primary_frame_sync_pin_out_en,
  output logic primary_autodetect_en,
  output logic primary_internal_frame_sync,
  output logic secondary_bclk_out_en,
  output logic secondary_frame_sync_pin_out_en,
  output logic secondary_autodetect_en,
  output logic secondary_internal_frame_sync,
  output logic [3:0] channel_enable,
  output logic rate_converter_enable,
  output logic rate_autodetect_en,
  output logic main_rate_from_secondary,
  output logic ratio_num_auto,
  output logic [2:0] ratio_num_value,
  output logic ratio_den_auto,
  output logic [2:0] ratio_den_value,
  output logic ratio_code_reserved
);
  import arc_pkg::*;

  logic [7:0] page;
  logic [7:0] port_role_frame_sync_pin_config;
  logic [7:0] dynamic_channel_limit_config;
  logic [7:0] rate_converter_control;
  logic [7:0] rate_converter_ratio_config;

  // page selector is reachable on every page
  wire page_sel_hit = (reg_addr == ARC_PAGE_ADDR);
  wire on_bank_page = (page == ARC_PAGE_CFG);
  wire role_hit = on_bank_page && (reg_addr == ARC_PORT_ROLE_ADDR);
  wire chan_hit = on_bank_page && (reg_addr == ARC_CHAN_LIMIT_ADDR);
  wire ctrl_hit = on_bank_page && (reg_addr == ARC_RC_CTRL_ADDR);
  wire ratio_hit = on_bank_page && (reg_addr == ARC_RC_RATIO_ADDR);

  // reserved positions are dropped so they always read back as zero
  wire [7:0] next_role = reg_wdata & ARC_PORT_ROLE_MASK;
  wire [7:0] next_chan = reg_wdata & ARC_CHAN_LIMIT_MASK;
  wire [7:0] next_ctrl = reg_wdata & ARC_RC_CTRL_MASK;
  wire [7:0] next_ratio = reg_wdata & ARC_RC_RATIO_MASK;

  wire [7:0] next_rdata = page_sel_hit ? page :
                          role_hit ? port_role_frame_sync_pin_config :
                          chan_hit ? dynamic_channel_limit_config :
                          ctrl_hit ? rate_converter_control :
                          ratio_hit ? rate_converter_ratio_config :
                          ARC_RESET_VALUE;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      page <= ARC_RESET_VALUE;
      port_role_frame_sync_pin_config <= ARC_RESET_VALUE;
      dynamic_channel_limit_config <= ARC_RESET_VALUE;
      rate_converter_control <= ARC_RESET_VALUE;
      rate_converter_ratio_config <= ARC_RESET_VALUE;
    end else if (reg_write) begin
      if (page_sel_hit) page <= reg_wdata;
      if (role_hit) port_role_frame_sync_pin_config <= next_role;
      if (chan_hit) dynamic_channel_limit_config <= next_chan;
      if (ctrl_hit) rate_converter_control <= next_ctrl;
      if (ratio_hit) rate_converter_ratio_config <= next_ratio;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= ARC_RESET_VALUE;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_read;
      if (reg_read) reg_rdata <= next_rdata;
    end
  end

  // port role resolution
  wire pri_ovr = port_role_frame_sync_pin_config[ARC_PRI_OVR_BIT];
  wire sec_ovr = port_role_frame_sync_pin_config[ARC_SEC_OVR_BIT];
  // normal role: controller drives both clocks, target drives neither
  wire next_pri_bclk = pri_ovr ? primary_role_select : primary_role_select;
  wire next_pri_frame_sync_pin = pri_ovr ? !primary_role_select : primary_role_select;
  wire next_sec_bclk = secondary_role_select;
  wire next_sec_frame_sync_pin = sec_ovr ? !secondary_role_select : secondary_role_select;
  // internal frame sync applies only while the port is a plain controller
  wire pri_controller = primary_role_select && !pri_ovr;
  wire sec_controller = secondary_role_select && !sec_ovr;
  wire next_pri_int_fs = pri_controller && port_role_frame_sync_pin_config[ARC_PRI_INT_FS_BIT];
  wire next_sec_int_fs = sec_controller && port_role_frame_sync_pin_config[ARC_SEC_INT_FS_BIT];

  // channel limit
  wire force_custom_channel_limit = dynamic_channel_limit_config[ARC_FORCE_CUST_BIT];
  wire [3:0] custom_channel_mask =
    dynamic_channel_limit_config[ARC_MASK_MSB:ARC_MASK_LSB];
  wire [3:0] next_chan_en;
  genvar ch;
  generate
    for (ch = 0; ch < ARC_NUM_CH; ch++) begin : g_chan
      // mask bit ch enables channel ch+1
      assign next_chan_en[ch] = force_custom_channel_limit ? custom_channel_mask[ch] :
                                standard_channel_limit_select[ch];
    end
  endgenerate

  // rate converter
  wire main_rate_manual = rate_converter_ratio_config[ARC_MAIN_MAN_BIT];
  wire main_rate_source = rate_converter_ratio_config[ARC_MAIN_SRC_BIT];
  wire inferred_secondary = !main_rate_auto_primary;
  wire next_main_sec = main_rate_manual ? main_rate_source : inferred_secondary;
  wire num_auto;
  wire num_rsv;
  wire [2:0] num_val;
  wire den_auto;
  wire den_rsv;
  wire [2:0] den_val;

  arc_ratio_decode u_num (
    .code(rate_converter_ratio_config[ARC_NUM_MSB:ARC_NUM_LSB]),
    .is_auto(num_auto),
    .is_reserved(num_rsv),
    .value(num_val)
  );

  arc_ratio_decode u_den (
    .code(rate_converter_ratio_config[ARC_DEN_MSB:ARC_DEN_LSB]),
    .is_auto(den_auto),
    .is_reserved(den_rsv),
    .value(den_val)
  );

  // next values of the remaining outputs
  wire next_pri_autodetect = !pri_ovr;
  wire next_sec_autodetect = !sec_ovr;
  wire next_rc_enable = rate_converter_control[ARC_RC_EN_BIT];
  wire next_rate_autodetect = !rate_converter_control[ARC_AUTO_DIS_BIT];
  wire next_ratio_reserved = num_rsv || den_rsv;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      active_page <= ARC_RESET_VALUE;
    end else begin
      active_page <= page;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      primary_bclk_out_en <= 1'b0;
    end else begin
      primary_bclk_out_en <= next_pri_bclk;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      primary_frame_sync_pin_out_en <= 1'b0;
    end else begin
      primary_frame_sync_pin_out_en <= next_pri_frame_sync_pin;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      primary_autodetect_en <= 1'b1;
    end else begin
      primary_autodetect_en <= next_pri_autodetect;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      primary_internal_frame_sync <= 1'b0;
    end else begin
      primary_internal_frame_sync <= next_pri_int_fs;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      secondary_bclk_out_en <= 1'b0;
    end else begin
      secondary_bclk_out_en <= next_sec_bclk;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      secondary_frame_sync_pin_out_en <= 1'b0;
    end else begin
      secondary_frame_sync_pin_out_en <= next_sec_frame_sync_pin;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      secondary_autodetect_en <= 1'b1;
    end else begin
      secondary_autodetect_en <= next_sec_autodetect;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      secondary_internal_frame_sync <= 1'b0;
    end else begin
      secondary_internal_frame_sync <= next_sec_int_fs;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      channel_enable <= 4'h0;
    end else begin
      channel_enable <= next_chan_en;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rate_converter_enable <= 1'b0;
    end else begin
      rate_converter_enable <= next_rc_enable;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rate_autodetect_en <= 1'b1;
    end else begin
      rate_autodetect_en <= next_rate_autodetect;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      main_rate_from_secondary <= 1'b0;
    end else begin
      main_rate_from_secondary <= next_main_sec;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ratio_num_auto <= 1'b1;
    end else begin
      ratio_num_auto <= num_auto;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ratio_num_value <= ARC_RATIO_AUTO;
    end else begin
      ratio_num_value <= num_val;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ratio_den_auto <= 1'b1;
    end else begin
      ratio_den_auto <= den_auto;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ratio_den_value <= ARC_RATIO_AUTO;
    end else begin
      ratio_den_value <= den_val;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ratio_code_reserved <= 1'b0;
    end else begin
      ratio_code_reserved <= next_ratio_reserved;
    end
  end
endmodule : arc_config_bank
`default_nettype wire

// >>> src/arc_pkg.sv
// package of register map constants for the audio port clock and rate configuration bank
`default_nettype none
package arc_pkg;
  localparam logic [7:0] ARC_PAGE_ADDR = 8'h00;
  localparam logic [7:0] ARC_PAGE_CFG = 8'h01;
  localparam logic [7:0] ARC_PORT_ROLE_ADDR = 8'h0D;
  localparam logic [7:0] ARC_CHAN_LIMIT_ADDR = 8'h0E;
  localparam logic [7:0] ARC_RC_CTRL_ADDR = 8'h17;
  localparam logic [7:0] ARC_RC_RATIO_ADDR = 8'h18;
  localparam logic [7:0] ARC_RESET_VALUE = 8'h00;
  // writable bits of each register; reserved bits stay zero
  localparam logic [7:0] ARC_PORT_ROLE_MASK = 8'hC6;
  localparam logic [7:0] ARC_CHAN_LIMIT_MASK = 8'hF8;
  localparam logic [7:0] ARC_RC_CTRL_MASK = 8'hC0;
  localparam logic [7:0] ARC_RC_RATIO_MASK = 8'hFF;
  localparam int ARC_PRI_OVR_BIT = 7;
  localparam int ARC_SEC_OVR_BIT = 6;
  localparam int ARC_PRI_INT_FS_BIT = 2;
  localparam int ARC_SEC_INT_FS_BIT = 1;
  localparam int ARC_FORCE_CUST_BIT = 7;
  localparam int ARC_MASK_LSB = 3;
  localparam int ARC_MASK_MSB = 6;
  localparam int ARC_RC_EN_BIT = 7;
  localparam int ARC_AUTO_DIS_BIT = 6;
  localparam int ARC_MAIN_MAN_BIT = 7;
  localparam int ARC_MAIN_SRC_BIT = 6;
  localparam int ARC_NUM_LSB = 3;
  localparam int ARC_NUM_MSB = 5;
  localparam int ARC_DEN_LSB = 0;
  localparam int ARC_DEN_MSB = 2;
  localparam int ARC_NUM_CH = 4;
  // ratio term codes
  localparam logic [2:0] ARC_RATIO_AUTO = 3'h0;
  localparam logic [2:0] ARC_RATIO_RSV5 = 3'h5;
  localparam logic [2:0] ARC_RATIO_SIX = 3'h6;
  localparam logic [2:0] ARC_RATIO_RSV7 = 3'h7;
endpackage : arc_pkg
`default_nettype wire

// >>> src/arc_ratio_decode.sv
// decoder for one main to auxiliary ratio term
`default_nettype none
module arc_ratio_decode (
  input wire logic [2:0] code,
  output logic is_auto,
  output logic is_reserved,
  output logic [2:0] value
);
  import arc_pkg::*;
  wire reserved_code = (code == ARC_RATIO_RSV5) || (code == ARC_RATIO_RSV7);
  assign is_auto = (code == ARC_RATIO_AUTO);
  assign is_reserved = reserved_code;
  // literal codes 1..4 and 6 carry their own value
  assign value = reserved_code ? ARC_RATIO_AUTO : code;
endmodule : arc_ratio_decode
`default_nettype wire

// >>> testbench/arc_cfg_assertions.sv
// checker for the page 1 configuration bank outputs
`default_nettype none
module arc_cfg_chk (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic reg_read,
  input wire logic reg_rvalid,
  input wire logic primary_bclk_out_en,
  input wire logic primary_frame_sync_pin_out_en,
  input wire logic primary_autodetect_en,
  input wire logic primary_internal_frame_sync,
  input wire logic secondary_bclk_out_en,
  input wire logic secondary_frame_sync_pin_out_en,
  input wire logic secondary_autodetect_en,
  input wire logic secondary_internal_frame_sync,
  input wire logic ratio_num_auto,
  input wire logic [2:0] ratio_num_value,
  input wire logic [2:0] ratio_den_value
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  a_read_valid_pulse: assert property (reg_rvalid == $past(reg_read))
    else $error("read valid not one cycle after read");
  a_pri_follow_role: assert property (primary_autodetect_en |->
    primary_bclk_out_en == primary_frame_sync_pin_out_en)
    else $error("primary port directions split without override");
  a_pri_ovr_split: assert property (!primary_autodetect_en |->
    primary_bclk_out_en != primary_frame_sync_pin_out_en)
    else $error("primary override directions not opposite");
  a_sec_ovr_split: assert property (secondary_autodetect_en ^
    (secondary_bclk_out_en != secondary_frame_sync_pin_out_en))
    else $error("secondary override directions wrong");
  a_pri_int_frame_sync_pin: assert property (primary_internal_frame_sync |->
    primary_bclk_out_en && primary_autodetect_en)
    else $error("primary internal frame sync outside controller mode");
  a_sec_int_frame_sync_pin: assert property (secondary_internal_frame_sync |->
    secondary_bclk_out_en && secondary_autodetect_en)
    else $error("secondary internal frame sync outside controller mode");
  a_num_auto_zero: assert property (ratio_num_auto |-> ratio_num_value == 3'h0)
    else $error("auto numerator carries a value");
  a_den_legal: assert property (ratio_den_value != 3'h5 && ratio_den_value != 3'h7)
    else $error("denominator value is a reserved code");
  c_pri_ovr: cover property (!primary_autodetect_en && primary_bclk_out_en);
  c_sec_int: cover property (secondary_internal_frame_sync);
  c_read: cover property (reg_read ##1 reg_rvalid);
endmodule : arc_cfg_chk
bind arc_config_bank arc_cfg_chk u_arc_cfg_chk (.sys_clk, .reset_n, .reg_read, .reg_rvalid,
  .primary_bclk_out_en, .primary_frame_sync_pin_out_en, .primary_autodetect_en, .primary_internal_frame_sync,
  .secondary_bclk_out_en, .secondary_frame_sync_pin_out_en, .secondary_autodetect_en,
  .secondary_internal_frame_sync, .ratio_num_auto, .ratio_num_value, .ratio_den_value);
`default_nettype wire

// >>> testbench/tb_top.sv
// self-checking bench for the page 1 configuration bank
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin fails++; \
  $display("BAD %0t mismatch", $time); end end
module tb_top import arc_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 0, reset_n = 0, reg_write = 0, reg_read = 0, main_rate_auto_primary = 0;
  logic primary_role_select = 0, secondary_role_select = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, active_page;
  logic [3:0] standard_channel_limit_select = 4'h0, channel_enable;
  logic reg_rvalid, primary_bclk_out_en, primary_frame_sync_pin_out_en, primary_autodetect_en;
  logic primary_internal_frame_sync, secondary_bclk_out_en, secondary_frame_sync_pin_out_en;
  logic secondary_autodetect_en, secondary_internal_frame_sync, rate_converter_enable;
  logic rate_autodetect_en, main_rate_from_secondary, ratio_num_auto, ratio_den_auto;
  logic ratio_code_reserved;
  logic [2:0] ratio_num_value, ratio_den_value;
  logic [7:0] exp_q[$];
  logic [7:0] adr[4] = '{ARC_PORT_ROLE_ADDR, ARC_CHAN_LIMIT_ADDR,
    ARC_RC_CTRL_ADDR, ARC_RC_RATIO_ADDR};
  logic [7:0] msk[4] = '{ARC_PORT_ROLE_MASK, ARC_CHAN_LIMIT_MASK,
    ARC_RC_CTRL_MASK, ARC_RC_RATIO_MASK};
  logic [7:0] r[4];
  logic [15:0] seed = 16'h7C40;
  int fails = 0, tests_run = 0;
  arc_config_bank u_arc_config_bank (.sys_clk, .reset_n, .reg_write, .reg_read, .reg_addr,
    .reg_wdata, .reg_rdata, .reg_rvalid, .primary_role_select, .secondary_role_select,
    .standard_channel_limit_select, .main_rate_auto_primary, .active_page, .primary_bclk_out_en,
    .primary_frame_sync_pin_out_en, .primary_autodetect_en, .primary_internal_frame_sync,
    .secondary_bclk_out_en, .secondary_frame_sync_pin_out_en, .secondary_autodetect_en,
    .secondary_internal_frame_sync, .channel_enable, .rate_converter_enable, .rate_autodetect_en,
    .main_rate_from_secondary, .ratio_num_auto, .ratio_num_value, .ratio_den_auto,
    .ratio_den_value, .ratio_code_reserved);
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic logic rsv(input logic [2:0] c);
    return c == ARC_RATIO_RSV5 || c == ARC_RATIO_RSV7;
  endfunction : rsv
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk) {reg_write, reg_addr, reg_wdata} = {1'b1, a, d};
    @(negedge sys_clk) reg_write = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge sys_clk) {reg_read, reg_addr} = {1'b1, a};
    exp_q.push_back(e);
    @(negedge sys_clk) reg_read = 1'b0;
  endtask : rd
  // scoreboard: each read answer is matched against the oldest note
  always @(negedge sys_clk) begin
    if (reg_rvalid === 1'b1) begin
      if (exp_q.size() == 0) `CHK(1'b0, 1'b1) else `CHK(reg_rdata, exp_q.pop_front())
    end
  end
  task automatic chk_cfg();
    logic p, s;
    logic [2:0] n, d;
    n = r[3][5:3];
    d = r[3][2:0];
    p = primary_role_select;
    s = secondary_role_select;
    `CHK(primary_bclk_out_en, p)
    `CHK(primary_frame_sync_pin_out_en, r[0][7] ? !p : p)
    `CHK(primary_autodetect_en, !r[0][7])
    `CHK({secondary_bclk_out_en, secondary_frame_sync_pin_out_en}, {s, r[0][6] ? !s : s})
    `CHK(secondary_autodetect_en, !r[0][6])
    `CHK(primary_internal_frame_sync, !r[0][7] && p && r[0][2])
    `CHK(secondary_internal_frame_sync, !r[0][6] && s && r[0][1])
    `CHK(channel_enable, r[1][7] ? r[1][6:3] : standard_channel_limit_select)
    `CHK({rate_converter_enable, rate_autodetect_en}, {r[2][7], !r[2][6]})
    `CHK(main_rate_from_secondary, r[3][7] ? r[3][6] : !main_rate_auto_primary)
    `CHK({ratio_num_auto, ratio_num_value}, {n == 3'h0, rsv(n) ? 3'h0 : n})
    `CHK({ratio_den_auto, ratio_den_value}, {d == 3'h0, rsv(d) ? 3'h0 : d})
    `CHK(ratio_code_reserved, rsv(n) || rsv(d))
  endtask : chk_cfg
  task automatic final_report();
    $display("checks %0d errors %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : final_report
  initial begin
    #300000;
    fails++;
    final_report();
  end
  initial begin
    r = '{default: 8'h00};
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk) reset_n = 1'b1;
    repeat (2) @(negedge sys_clk);
    chk_cfg();
    wr(ARC_RC_CTRL_ADDR, 8'hC0);
    rd(ARC_RC_CTRL_ADDR, 8'h00);
    wr(ARC_PAGE_ADDR, ARC_PAGE_CFG);
    rd(ARC_PAGE_ADDR, ARC_PAGE_CFG);
    `CHK(active_page, ARC_PAGE_CFG)
    for (int i = 0; i < 4; i++) begin
      wr(adr[i], msk[i]);
      rd(adr[i], msk[i]);
    end
    rd(8'h20, 8'h00);
    for (int i = 0; i < 40; i++) begin
      seed = lfsr(seed);
      {primary_role_select, secondary_role_select, main_rate_auto_primary} = seed[2:0];
      standard_channel_limit_select = seed[6:3];
      for (int k = 0; k < 4; k++) begin
        seed = lfsr(seed);
        r[k] = seed[7:0] & msk[k];
      end
      r[3][5:0] = {i[2:0], 3'(7 - i)};
      for (int k = 0; k < 4; k++) wr(adr[k], r[k]);
      repeat (2) @(negedge sys_clk);
      chk_cfg();
      rd(adr[i % 4], r[i % 4]);
    end
    wr(ARC_PAGE_ADDR, 8'h02);
    wr(ARC_RC_CTRL_ADDR, ~r[2] & ARC_RC_CTRL_MASK);
    wr(ARC_PAGE_ADDR, ARC_PAGE_CFG);
    rd(ARC_RC_CTRL_ADDR, r[2]);
    for (int i = 0; i < 10 && exp_q.size() > 0; i++) @(negedge sys_clk);
    if (exp_q.size() > 0) fails++;
    final_report();
  end
endmodule : tb_top
`default_nettype wire
